// ---- rtl/swm_master.v ----
// Single-wire bus master: reset/presence, write and read time slots.
// Assumes an open-drain line with an external pullup; the pin is async.
`timescale 1ns/10ps
`default_nettype none
`include "swm_defines.vh"

module swm_master
#(
   parameter RESET_LOW_CYC = `SWM_RESET_LOW_CYC,
   parameter RESET_HIGH_CYC = `SWM_RESET_HIGH_CYC,
   parameter PRESENCE_SAMPLE_CYC = `SWM_PRESENCE_SAMPLE_CYC,
   parameter WRITE_ONE_LOW_CYC = `SWM_WRITE_ONE_LOW_CYC,
   parameter WRITE_ZERO_LOW_CYC = `SWM_WRITE_ZERO_LOW_CYC,
   parameter READ_LOW_CYC = `SWM_READ_LOW_CYC,
   parameter READ_SAMPLE_CYC = `SWM_READ_SAMPLE_CYC,
   parameter SLOT_CYC = `SWM_SLOT_CYC,
   parameter RECOVERY_CYC = `SWM_RECOVERY_CYC
)
(
   input wire clk_sys,
   input wire nrst,
   input wire cmd_valid,
   input wire [1:0] cmd_op,
   input wire [7:0] cmd_data,
   output reg cmd_ready,
   output reg done,
   output reg err,
   output reg presence,
   output reg [7:0] rd_data,
   output reg busy,
   input wire line_in,
   output reg line_out,
   output reg line_oe
);

   // ------------------------------------------------------------------
   // Local constants
   // ------------------------------------------------------------------
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_RST_LOW = 3'h1;
   localparam [2:0] ST_RST_HIGH = 3'h2;
   localparam [2:0] ST_SLOT_LOW = 3'h3;
   localparam [2:0] ST_SLOT_HIGH = 3'h4;
   localparam [2:0] ST_SLOT_REC = 3'h5;

   // Last-cycle and sample-point compare values for the 16-bit timer
   localparam [15:0] T_RST_LOW = RESET_LOW_CYC[15:0] - 16'h0001;
   localparam [15:0] T_RST_HIGH = RESET_HIGH_CYC[15:0] - 16'h0001;
   // The synced pin lags the timer compare, so the compare waits longer
   localparam [15:0] T_PRES = PRESENCE_SAMPLE_CYC[15:0] + `SWM_SYNC_LAT;
   localparam [15:0] T_W1_LOW = WRITE_ONE_LOW_CYC[15:0] - 16'h0001;
   localparam [15:0] T_W0_LOW = WRITE_ZERO_LOW_CYC[15:0] - 16'h0001;
   localparam [15:0] T_RD_LOW = READ_LOW_CYC[15:0] - 16'h0001;
   // Delay added so the first flop catches the pin at the maximum
   localparam [15:0] T_SAMPLE = READ_SAMPLE_CYC[15:0] + `SWM_SYNC_LAT;
   localparam [15:0] T_SLOT = SLOT_CYC[15:0] - 16'h0001;
   localparam [15:0] T_REC = RECOVERY_CYC[15:0] - 16'h0001;

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   reg [2:0] state;
   reg [15:0] timer;
   reg [1:0] op;
   reg [7:0] sh;
   reg [2:0] bitcnt;
   reg smp;
   reg found;
   reg linked;
   wire line_s;
   wire slot_bit;
   wire last_bit;
   reg [15:0] low_end;

   // ------------------------------------------------------------------
   // Pin synchroniser
   // ------------------------------------------------------------------
   swm_sync u_sync
   (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .din(line_in),
      .dout(line_s)
   );

   // ------------------------------------------------------------------
   // Slot decode
   // ------------------------------------------------------------------
   // A read slot is sent as a write-one, so the slave can pull it down
   assign slot_bit = (op == `SWM_OP_READ_BYTE) ? 1'b1 : sh[0];
   // A single-bit request ends after one slot, a byte after eight
   assign last_bit = (op == `SWM_OP_BIT) || (bitcnt == 3'h7);

   always @*
   begin
      low_end = T_W0_LOW;
      if (op == `SWM_OP_READ_BYTE)
      begin
         low_end = T_RD_LOW;
      end
      else if (slot_bit)
      begin
         low_end = T_W1_LOW;
      end
   end

   // ------------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------------
   always @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         state <= ST_IDLE;
         timer <= 16'h0000;
         op <= 2'h0;
         sh <= 8'h00;
         bitcnt <= 3'h0;
         smp <= 1'b1;
         found <= 1'b0;
         linked <= 1'b0;
         cmd_ready <= 1'b0;
         done <= 1'b0;
         err <= 1'b0;
         presence <= 1'b0;
         rd_data <= 8'h00;
         busy <= 1'b0;
         line_out <= 1'b0;
         line_oe <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         line_out <= 1'b0;
         case (state)
            ST_IDLE:
            begin
               cmd_ready <= 1'b1;
               busy <= 1'b0;
               line_oe <= 1'b0;
               if (cmd_valid && cmd_ready)
               begin
                  op <= cmd_op;
                  timer <= 16'h0000;
                  bitcnt <= 3'h0;
                  err <= 1'b0;
                  if (cmd_op == `SWM_OP_RESET)
                  begin
                     // Every exchange is opened by the master
                     cmd_ready <= 1'b0;
                     busy <= 1'b1;
                     linked <= 1'b0;
                     found <= 1'b0;
                     line_oe <= 1'b1;
                     state <= ST_RST_LOW;
                  end
                  else if (!linked)
                  begin
                     // No slave listens before a handshake; refuse at once
                     done <= 1'b1;
                     err <= 1'b1;
                  end
                  else
                  begin
                     cmd_ready <= 1'b0;
                     busy <= 1'b1;
                     if (cmd_op == `SWM_OP_BIT)
                     begin
                        sh <= {7'h00, cmd_data[0]};
                     end
                     else
                     begin
                        sh <= cmd_data;
                     end
                     line_oe <= 1'b1;
                     state <= ST_SLOT_LOW;
                  end
               end
            end

            ST_RST_LOW:
            begin
               timer <= timer + 16'h0001;
               // Reset low covers the fall time of a slowed edge too
               if (timer == T_RST_LOW)
               begin
                  line_oe <= 1'b0;
                  timer <= 16'h0000;
                  state <= ST_RST_HIGH;
               end
            end

            ST_RST_HIGH:
            begin
               timer <= timer + 16'h0001;
               // A low level here can only be a slave answering the reset
               if (timer == T_PRES)
               begin
                  found <= ~line_s;
               end
               // The full high time passes before any new slot or reset
               if (timer == T_RST_HIGH)
               begin
                  presence <= found;
                  linked <= found;
                  err <= ~found;
                  done <= 1'b1;
                  cmd_ready <= 1'b1;
                  busy <= 1'b0;
                  state <= ST_IDLE;
               end
            end

            ST_SLOT_LOW:
            begin
               timer <= timer + 16'h0001;
               if (timer == T_SAMPLE)
               begin
                  smp <= line_s;
               end
               if (timer == low_end)
               begin
                  line_oe <= 1'b0;
                  state <= ST_SLOT_HIGH;
               end
            end

            ST_SLOT_HIGH:
            begin
               timer <= timer + 16'h0001;
               // Zero from the slave shows as a line still held low
               if (timer == T_SAMPLE)
               begin
                  smp <= line_s;
               end
               // Wait out the whole slot whatever was sampled
               if (timer == T_SLOT)
               begin
                  sh <= {smp, sh[7:1]};
                  timer <= 16'h0000;
                  state <= ST_SLOT_REC;
               end
            end

            ST_SLOT_REC:
            begin
               timer <= timer + 16'h0001;
               // Slave needs this gap, also before the next request
               if (timer == T_REC)
               begin
                  timer <= 16'h0000;
                  if (last_bit)
                  begin
                     if (op == `SWM_OP_BIT)
                     begin
                        rd_data <= {7'h00, sh[7]};
                     end
                     else
                     begin
                        rd_data <= sh;
                     end
                     done <= 1'b1;
                     cmd_ready <= 1'b1;
                     busy <= 1'b0;
                     state <= ST_IDLE;
                  end
                  else
                  begin
                     // One bit per slot, next bit in a fresh slot
                     bitcnt <= bitcnt + 3'h1;
                     line_oe <= 1'b1;
                     state <= ST_SLOT_LOW;
                  end
               end
            end

            default:
            begin
               line_oe <= 1'b0;
               state <= ST_IDLE;
            end
         endcase
      end
   end

endmodule

`default_nettype wire

// ---- common/swm_defines.vh ----
// Timing constants and command codes for the single-wire bus master.
// Assumes a 10 ns system clock; all times below are in nanoseconds.
`ifndef SWM_DEFINES_VH
`define SWM_DEFINES_VH

// ----------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------
`define SWM_CLK_NS 10

// ----------------------------------------------------------------------
// Line times, as figures in ns
// ----------------------------------------------------------------------
`define SWM_RESET_LOW_NS 480000
`define SWM_FALL_NS 100
`define SWM_RESET_HIGH_NS 480000
`define SWM_PRESENCE_SAMPLE_NS 70000
`define SWM_WRITE_ONE_LOW_NS 6000
`define SWM_WRITE_ZERO_LOW_NS 60000
`define SWM_READ_LOW_NS 6000
`define SWM_READ_SAMPLE_NS 13000
`define SWM_SLOT_NS 65000
`define SWM_RECOVERY_NS 5000

// ----------------------------------------------------------------------
// Cycle counts; least times round up, longest times round down
// ----------------------------------------------------------------------
`define SWM_CYC_UP(ns) (((ns) + `SWM_CLK_NS - 1) / `SWM_CLK_NS)
`define SWM_CYC_DN(ns) ((ns) / `SWM_CLK_NS)
`define SWM_RESET_LOW_CYC `SWM_CYC_UP(`SWM_RESET_LOW_NS + `SWM_FALL_NS)
`define SWM_RESET_HIGH_CYC `SWM_CYC_UP(`SWM_RESET_HIGH_NS)
`define SWM_PRESENCE_SAMPLE_CYC `SWM_CYC_UP(`SWM_PRESENCE_SAMPLE_NS)
`define SWM_WRITE_ONE_LOW_CYC `SWM_CYC_DN(`SWM_WRITE_ONE_LOW_NS)
`define SWM_WRITE_ZERO_LOW_CYC `SWM_CYC_UP(`SWM_WRITE_ZERO_LOW_NS)
`define SWM_READ_LOW_CYC `SWM_CYC_UP(`SWM_READ_LOW_NS)
`define SWM_READ_SAMPLE_CYC `SWM_CYC_DN(`SWM_READ_SAMPLE_NS)
`define SWM_SLOT_CYC `SWM_CYC_UP(`SWM_SLOT_NS)
`define SWM_RECOVERY_CYC `SWM_CYC_UP(`SWM_RECOVERY_NS)

// ----------------------------------------------------------------------
// Synchroniser depth and command codes
// ----------------------------------------------------------------------
`define SWM_SYNC_LAT 16'h0003
`define SWM_OP_RESET 2'h0
`define SWM_OP_WRITE_BYTE 2'h1
`define SWM_OP_READ_BYTE 2'h2
`define SWM_OP_BIT 2'h3

`endif

// ---- rtl/swm_sync.v ----
// Three-stage input synchroniser with agreement filter for the line pin.
// Assumes the pin is asynchronous to clk_sys and idles high.
`timescale 1ns/10ps
`default_nettype none

module swm_sync
(
   input wire clk_sys,
   input wire nrst,
   input wire din,
   output reg dout
);

   reg s1;
   reg s2;
   reg s3;

   // ------------------------------------------------------------------
   // Stages; s1 feeds s2 only, to keep metastability contained
   // ------------------------------------------------------------------
   always @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         s1 <= 1'b1;
         s2 <= 1'b1;
         s3 <= 1'b1;
         dout <= 1'b1;
      end
      else
      begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3)
         begin
            dout <= s3;
         end
      end
   end

endmodule

`default_nettype wire

// ---- testbench/swm_chk_sva.sv ----
// Checker on the bus master ports.
// Assumes the bus master as top, one clock domain.
`timescale 1ns/10ps
`default_nettype none
module swm_chk
#(
   parameter int RESET_LOW_CYC = 40,
   parameter int RESET_HIGH_CYC = 40,
   parameter int WRITE_ONE_LOW_CYC = 2,
   parameter int WRITE_ZERO_LOW_CYC = 8,
   parameter int READ_LOW_CYC = 2,
   parameter int SLOT_CYC = 12,
   parameter int RECOVERY_CYC = 3
)
(
   input wire clk_sys,
   input wire nrst,
   input wire cmd_valid,
   input wire [1:0] cmd_op,
   input wire cmd_ready,
   input wire done,
   input wire err,
   input wire presence,
   input wire line_out,
   input wire line_oe
);
   // ---------------
   // Run counters
   // ---------------
   logic [15:0] lo_cnt, hi_cnt, sl_cnt;
   logic [1:0] last_op;
   logic last_ref, prev_oe;
   int t_cnt, exp_lat;
   wire take = cmd_valid && cmd_ready;
   always @(posedge clk_sys)
   begin
      prev_oe <= line_oe;
      lo_cnt <= line_oe ? lo_cnt + 16'h1 : 16'h0;
      hi_cnt <= line_oe ? 16'h0 : hi_cnt + {15'h0, hi_cnt != 16'hffff};
      sl_cnt <= sl_cnt + {15'h0, sl_cnt != 16'hffff};
      if (line_oe && !prev_oe)
         sl_cnt <= 16'h1;
      t_cnt <= take ? 1 : t_cnt + 1;
      if (take)
      begin
         last_op <= cmd_op;
         last_ref <= cmd_op != 2'h0 && !presence;
      end
      if (!nrst)
      begin
         lo_cnt <= 16'h0;
         hi_cnt <= 16'hffff;
         sl_cnt <= 16'hffff;
         last_op <= 2'h0;
         last_ref <= 1'b0;
         prev_oe <= 1'b0;
      end
   end
   always_comb
      if (last_ref)
         exp_lat = 1;
      else if (last_op == 2'h0)
         exp_lat = RESET_LOW_CYC + RESET_HIGH_CYC + 1;
      else if (last_op == 2'h3)
         exp_lat = SLOT_CYC + RECOVERY_CYC + 1;
      else
         exp_lat = 8 * (SLOT_CYC + RECOVERY_CYC) + 1;
   // ---------------
   // Properties
   // ---------------
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   open_drain_a: assert property (!line_out)
      else $error("line_out driven high");
   refuse_slot_a: assert property (take && cmd_op != 2'h0 && !presence
      |=> done && err && !line_oe) else $error("slot not refused");
   reset_low_a: assert property ($fell(line_oe) && last_op == 2'h0
      |-> lo_cnt == RESET_LOW_CYC) else $error("reset low length");
   write_low_a: assert property ($fell(line_oe) && last_op[0]
      |-> lo_cnt == WRITE_ONE_LOW_CYC || lo_cnt == WRITE_ZERO_LOW_CYC)
      else $error("write low length");
   read_low_a: assert property ($fell(line_oe) && last_op == 2'h2
      |-> lo_cnt == READ_LOW_CYC) else $error("read low length");
   recovery_a: assert property ($rose(line_oe)
      |-> hi_cnt >= RECOVERY_CYC) else $error("recovery too short");
   slot_gap_a: assert property ($rose(line_oe)
      |-> sl_cnt >= SLOT_CYC + RECOVERY_CYC) else $error("slot too short");
   low_limit_a: assert property (lo_cnt <= RESET_LOW_CYC)
      else $error("line held low too long");
   answer_lat_a: assert property (done |-> t_cnt == exp_lat)
      else $error("done at wrong cycle");
   presence_flag_a: assert property (done && last_op == 2'h0
      |-> err == !presence) else $error("presence and err disagree");
   cover property (take && cmd_op == 2'h0);
   cover property (done && !err && last_op == 2'h2);
   cover property (done && err && last_ref);
endmodule
bind swm_master swm_chk #(.RESET_LOW_CYC(RESET_LOW_CYC),
   .RESET_HIGH_CYC(RESET_HIGH_CYC), .WRITE_ONE_LOW_CYC(WRITE_ONE_LOW_CYC),
   .WRITE_ZERO_LOW_CYC(WRITE_ZERO_LOW_CYC), .READ_LOW_CYC(READ_LOW_CYC),
   .SLOT_CYC(SLOT_CYC), .RECOVERY_CYC(RECOVERY_CYC)) u_chk (
   .clk_sys(clk_sys), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
   .cmd_ready(cmd_ready), .done(done), .err(err), .presence(presence),
   .line_out(line_out), .line_oe(line_oe));
`default_nettype wire

// ---- testbench/swm_slave_model.sv ----
// Behavioural slave on the far end of the line.
// Assumes the pulled-up wire level on line; timed by clk_sys.
`timescale 1ns/10ps
`default_nettype none
module swm_slave_model
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic line,
   input wire logic present_en,
   input wire logic tx_en,
   input wire logic [7:0] tx_byte,
   output logic pull,
   output logic [7:0] rx_byte,
   output logic [7:0] viol
);
   // ---------------
   // Slot timer
   // ---------------
   logic prev, armed;
   logic [7:0] low_cnt, hi_cnt, pd_cnt, t;
   logic [2:0] idx;
   wire pull_p = present_en && pd_cnt != 8'h0 && pd_cnt <= 8'hc;
   // Answers only when told, so write slots are never disturbed
   wire pull_r = tx_en && armed && t != 8'h0 && !tx_byte[idx];
   assign pull = pull_p || pull_r;
   always @(posedge clk_sys)
      if (!nrst)
      begin
         prev <= 1'b1;
         armed <= 1'b0;
         low_cnt <= 8'h0;
         hi_cnt <= 8'h0;
         pd_cnt <= 8'h0;
         t <= 8'h0;
         idx <= 3'h0;
         rx_byte <= 8'h0;
         viol <= 8'h0;
      end
      else
      begin
         prev <= line;
         low_cnt <= line ? 8'h0 : low_cnt + {7'h0, low_cnt != 8'hff};
         hi_cnt <= line ? hi_cnt + {7'h0, hi_cnt != 8'hff} : 8'h0;
         if (pd_cnt != 8'h0)
            pd_cnt <= pd_cnt - 8'h1;
         if (pd_cnt == 8'h1)
            armed <= present_en;
         if (pd_cnt == 8'h1)
            idx <= 3'h0;
         if (t != 8'h0)
            t <= (t == 8'h9) ? 8'h0 : t + 8'h1;
         if (t == 8'h9)
            idx <= idx + 3'h1;
         if (t == 8'h5)
            rx_byte <= {line, rx_byte[7:1]};
         if (line && !prev && low_cnt >= 8'h1e)
         begin
            pd_cnt <= 8'hf;
            armed <= 1'b0;
            t <= 8'h0;
         end
         else if (!line && prev && !pull && armed)
         begin
            t <= 8'h1;
            if (hi_cnt < 8'h3)
               viol <= viol + 8'h1;
         end
      end
endmodule
`default_nettype wire

// ---- testbench/swm_master_tb_top.sv ----
// Self-checking bench for the single-wire bus master.
// Assumes the master as dut and the slave model on a pulled-up wire.
`timescale 1ns/10ps
`default_nettype none
module swm_master_tb_top;
   // ---------------
   // Harness
   // ---------------
   logic clk_sys, nrst, cmd_valid, present_en, tx_en;
   logic [1:0] cmd_op;
   logic [7:0] cmd_data, tx_byte;
   wire logic cmd_ready, done, err, presence, busy, line_out, line_oe, pull;
   wire logic [7:0] rd_data, rx_byte, viol;
   wire logic line = ~(line_oe | pull);
   int n_fail, total_checks;
   // Short timing set; the slave model is built around these figures
   localparam int RST_CYC = 40;
   localparam int LOW_CYC = 2;
   localparam int SLT_CYC = 12;
   localparam int REC_CYC = 3;
   swm_master #(.RESET_LOW_CYC(RST_CYC), .RESET_HIGH_CYC(RST_CYC),
      .PRESENCE_SAMPLE_CYC(RST_CYC / 4), .WRITE_ONE_LOW_CYC(LOW_CYC),
      .WRITE_ZERO_LOW_CYC(4 * LOW_CYC), .READ_LOW_CYC(LOW_CYC),
      .READ_SAMPLE_CYC(3 * LOW_CYC), .SLOT_CYC(SLT_CYC),
      .RECOVERY_CYC(REC_CYC)) dut (.clk_sys(clk_sys),
      .nrst(nrst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
      .cmd_data(cmd_data), .cmd_ready(cmd_ready), .done(done), .err(err),
      .presence(presence), .rd_data(rd_data), .busy(busy),
      .line_in(line), .line_out(line_out), .line_oe(line_oe));
   swm_slave_model u_slave (.clk_sys(clk_sys), .nrst(nrst), .line(line),
      .present_en(present_en), .tx_en(tx_en), .tx_byte(tx_byte),
      .pull(pull), .rx_byte(rx_byte), .viol(viol));
   task check(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task send(input logic [1:0] op, input logic [7:0] d);
      int n;
      logic hold;
      check({7'h0, cmd_ready}, 8'h1);
      cmd_op = op;
      cmd_data = d;
      cmd_valid = 1'b1;
      @(negedge clk_sys);
      cmd_valid = 1'b0;
      hold = busy;
      n = 0;
      while (done !== 1'b1 && n < 2000)
      begin
         @(negedge clk_sys);
         n++;
      end
      check({7'h0, done}, 8'h1);
      // Busy must stand for any request that runs on the line
      check({7'h0, hold}, {7'h0, n != 0});
      // Let an edge pass so the next request starts from a low strobe
      @(negedge clk_sys);
   endtask
   task close_out;
      $display("checks=%0d fails=%0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ---------------
   // Scenarios
   // ---------------
   task t_absent;
      send(2'h1, 8'hff);
      check({7'h0, err}, 8'h1);
      present_en = 1'b0;
      send(2'h0, 8'h0);
      check({6'h0, err, presence}, 8'h2);
      present_en = 1'b1;
      send(2'h2, 8'h0);
      check({7'h0, err}, 8'h1);
      check(rx_byte, 8'h0);
   endtask
   task t_write;
      send(2'h0, 8'h0);
      check({6'h0, err, presence}, 8'h1);
      send(2'h1, 8'ha5);
      check(rx_byte, 8'ha5);
      check(rd_data, 8'ha5);
      send(2'h1, 8'h3c);
      check(rx_byte, 8'h3c);
   endtask
   task t_read;
      tx_en = 1'b1;
      tx_byte = 8'h96;
      send(2'h2, 8'h0);
      check(rd_data, 8'h96);
      tx_en = 1'b0;
      send(2'h3, 8'h0);
      check(rx_byte, 8'h4b);
      tx_en = 1'b1;
      tx_byte = 8'h00;
      send(2'h3, 8'h1);
      check({7'h0, rd_data[0]}, 8'h0);
      tx_byte = 8'hff;
      send(2'h3, 8'h1);
      check({7'h0, rd_data[0]}, 8'h1);
      tx_en = 1'b0;
      check(viol, 8'h0);
   endtask
   task t_rearm;
      // A reset that finds nobody drops the link again
      present_en = 1'b0;
      send(2'h0, 8'h0);
      check({6'h0, err, presence}, 8'h2);
      present_en = 1'b1;
      send(2'h3, 8'h1);
      check({7'h0, err}, 8'h1);
      nrst = 1'b0;
      repeat (4) @(negedge clk_sys);
      nrst = 1'b1;
      repeat (2) @(negedge clk_sys);
      check({7'h0, presence}, 8'h0);
      send(2'h1, 8'h0);
      check({7'h0, err}, 8'h1);
   endtask
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial
   begin
      #100000;
      n_fail++;
      close_out;
   end
   initial
   begin
      nrst = 1'b0;
      cmd_valid = 1'b0;
      cmd_op = 2'h0;
      cmd_data = 8'h0;
      present_en = 1'b1;
      tx_en = 1'b0;
      tx_byte = 8'h0;
      n_fail = 0;
      total_checks = 0;
      // Four edges so the line synchroniser is flushed too
      repeat (4) @(negedge clk_sys);
      nrst = 1'b1;
      repeat (2) @(negedge clk_sys);
      t_absent;
      t_write;
      t_read;
      t_rearm;
      close_out;
   end
endmodule
`default_nettype wire
